// ### core/cps_pkg.sv
// Constants for the codec port status word and its companion registers.
// Assumes a 32-bit plain register port addressed in bytes.
package cps_pkg;
   localparam int          ADDR_W        = 8;
   localparam int          DATA_W        = 32;
   localparam int          WORD_W        = 16;
   localparam int          FIFO_DEPTH    = 8;
   localparam int          PTR_W         = 3;
   localparam int          CNT_W         = 4;
   localparam int          REG_IDX_W     = 4;
   localparam logic [7:0]  OFF_STATUS    = 8'h00;
   localparam logic [7:0]  OFF_MASK      = 8'h04;
   localparam logic [7:0]  OFF_CTRL      = 8'h08;
   localparam logic [7:0]  OFF_TXDATA    = 8'h0C;
   localparam logic [7:0]  OFF_RXDATA    = 8'h10;
   localparam int          BIT_TTU       = 6;
   localparam int          BIT_TRO       = 7;
   localparam int          BIT_ANF       = 8;
   localparam int          BIT_ANE       = 9;
   localparam int          BIT_TNF       = 10;
   localparam int          BIT_TNE       = 11;
   localparam int          BIT_CWC       = 12;
   localparam int          BIT_CRC       = 13;
   localparam int          BIT_ACE       = 14;
   localparam int          BIT_TCE       = 15;
   localparam logic [31:0] STICKY_MASK   = 32'h0000_30C0;
   localparam int          CTRL_CP_EN    = 0;
   localparam int          CTRL_SSF_EN   = 1;
   localparam logic [1:0]  CTRL_RESET    = 2'h0;
   localparam logic [3:0]  CODEC_REG_AUD = 4'h8;
   localparam logic [3:0]  CODEC_REG_TEL = 4'h6;
   localparam int          ENA_IN_BIT    = 14;
   localparam int          ENA_OUT_BIT   = 15;
   localparam logic [3:0]  LAST_BIT      = 4'hF;
   typedef enum logic [0:0] {
      CPS_IDLE,
      CPS_SHIFT
   } cps_ser_state_type;
endpackage

// ### core/cps_status.sv
// Upper status word of a serial codec port, its interrupt, control and a
// small transmit queue feeding the synchronous serial shifter.
// Assumes FIFO status and codec events arrive on clk; link pins are asynchronous.
// Function
// - Set telecom underrun on fetch from empty
// - Set telecom overrun on push into full
// - Bit 8 shows audio transmit space
// - Bit 9 shows audio receive entry held
// - Bit 10 shows telecom transmit space
// - Bit 11 shows telecom receive entry held
// - Bit 12 sets on completed codec write
// - Bit 13 sets when read data arrives
// - Bit 14 audio enables from codec register
// - Bit 15 telecom enables from codec register
// - Reset disables both, pins go to controller
// - Writing one clears interruptible flags
// - Codec port wins the shared pins
// - Transmit queue holds eight 16-bit words
// - Enabled shifter runs on clock and frame
// - Read-only and reserved writes ignored, read zero
`timescale 1ns/1ps
module cps_status (
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic [cps_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [cps_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                       reg_wr,
   input  wire logic                       reg_rd,
   output logic      [cps_pkg::DATA_W-1:0] reg_rdata,
   output logic                            irq,
   input  wire logic                       tel_tx_fetch,
   input  wire logic                       tel_tx_empty,
   input  wire logic                       tel_rx_push,
   input  wire logic                       tel_rx_full,
   input  wire logic                       aud_tx_full,
   input  wire logic                       aud_rx_empty,
   input  wire logic                       tel_tx_full,
   input  wire logic                       tel_rx_empty,
   input  wire logic                       codec_wr_done,
   input  wire logic [3:0]                 codec_wr_addr,
   input  wire logic [cps_pkg::WORD_W-1:0] codec_wr_data,
   input  wire logic                       codec_rd_done,
   output logic                            codec_port_en,
   output logic                            sync_serial_func_en,
   output logic                            pins_to_pin_controller,
   input  wire logic                       serial_clk_pin,
   input  wire logic                       serial_frame_pin,
   input  wire logic                       serial_rx_pin,
   output logic                            serial_tx_pin,
   output logic                            tx_service_req
);

   logic [cps_pkg::DATA_W-1:0] sticky_q;
   logic [cps_pkg::DATA_W-1:0] sticky_d;
   logic [cps_pkg::DATA_W-1:0] mask_q;
   logic [1:0]                 ctrl_q;
   logic                       aud_on_q;
   logic                       tel_on_q;
   logic                       aud_pend_q;
   logic                       tel_pend_q;
   logic                       aud_pend_val_q;
   logic                       tel_pend_val_q;
   logic [cps_pkg::DATA_W-1:0] status_word;
   logic [cps_pkg::DATA_W-1:0] set_vec;
   logic [cps_pkg::DATA_W-1:0] rdata_q;
   logic                       hit_status;
   logic                       hit_mask;
   logic                       hit_ctrl;
   logic                       hit_tx;
   logic                       hit_rx;
   logic                       ena_bits;

   // Link pin synchronisers; stage two feeds the edge finders through stage three
   logic [2:0]                 sclk_s_q;
   logic [2:0]                 frm_s_q;
   logic [1:0]                 rxp_s_q;
   logic                       sclk_rise;
   logic                       sclk_fall;
   logic                       frm_rise;

   logic [cps_pkg::WORD_W-1:0] fifo_mem [cps_pkg::FIFO_DEPTH];
   logic [cps_pkg::PTR_W-1:0]  wr_ptr_q;
   logic [cps_pkg::PTR_W-1:0]  rd_ptr_q;
   logic [cps_pkg::CNT_W-1:0]  cnt_q;
   logic                       fifo_full;
   logic                       fifo_empty;
   logic                       push;
   logic                       pop;

   cps_pkg::cps_ser_state_type state_q;
   logic [cps_pkg::WORD_W-1:0] tx_sh_q;
   logic [cps_pkg::WORD_W-1:0] rx_sh_q;
   logic [cps_pkg::WORD_W-1:0] rx_word_q;
   logic [3:0]                 bit_cnt_q;
   logic                       tx_pin_q;
   logic                       ssf_active;

   assign hit_status = (reg_addr == cps_pkg::OFF_STATUS);
   assign hit_mask   = (reg_addr == cps_pkg::OFF_MASK);
   assign hit_ctrl   = (reg_addr == cps_pkg::OFF_CTRL);
   assign hit_tx     = (reg_addr == cps_pkg::OFF_TXDATA);
   assign hit_rx     = (reg_addr == cps_pkg::OFF_RXDATA);

   // Event sources for the sticky flags
   always_comb begin
      set_vec                    = '0;
      set_vec[cps_pkg::BIT_TTU]  = tel_tx_fetch & tel_tx_empty;
      set_vec[cps_pkg::BIT_TRO]  = tel_rx_push & tel_rx_full;
      set_vec[cps_pkg::BIT_CWC]  = codec_wr_done;
      set_vec[cps_pkg::BIT_CRC]  = codec_rd_done;
   end

   // Set wins over a same-cycle clear so no event is lost
   always_comb begin
      sticky_d = sticky_q;
      if (reg_wr && hit_status) begin
         sticky_d = sticky_q & ~(reg_wdata & cps_pkg::STICKY_MASK);
      end
      sticky_d = (sticky_d | set_vec) & cps_pkg::STICKY_MASK;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sticky_q <= '0;
      end else begin
         sticky_q <= sticky_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mask_q <= '0;
      end else if (reg_wr && hit_mask) begin
         mask_q <= reg_wdata & cps_pkg::STICKY_MASK;
      end
   end

   // Reset leaves both functions off and the pins with the pin controller
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_q <= cps_pkg::CTRL_RESET;
      end else if (reg_wr && hit_ctrl) begin
         ctrl_q <= reg_wdata[1:0];
      end
   end

   assign codec_port_en          = ctrl_q[cps_pkg::CTRL_CP_EN];
   // Codec port owns the shared pins whenever it is enabled
   assign ssf_active             = ctrl_q[cps_pkg::CTRL_SSF_EN] & ~ctrl_q[cps_pkg::CTRL_CP_EN];
   assign sync_serial_func_en    = ssf_active;
   assign pins_to_pin_controller = ~ctrl_q[cps_pkg::CTRL_CP_EN] & ~ctrl_q[cps_pkg::CTRL_SSF_EN];
   assign irq                    = |(sticky_q & mask_q);

   // Link pin sampling
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sclk_s_q <= '0;
         frm_s_q  <= '0;
         rxp_s_q  <= '0;
      end else begin
         sclk_s_q <= {sclk_s_q[1:0], serial_clk_pin};
         frm_s_q  <= {frm_s_q[1:0], serial_frame_pin};
         rxp_s_q  <= {rxp_s_q[0], serial_rx_pin};
      end
   end

   assign sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
   assign sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
   assign frm_rise  = frm_s_q[1] & ~frm_s_q[2];

   assign ena_bits = codec_wr_data[cps_pkg::ENA_IN_BIT] | codec_wr_data[cps_pkg::ENA_OUT_BIT];

   // Enable flags change only at the next frame start after the codec write lands
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         aud_pend_q     <= 1'b0;
         aud_pend_val_q <= 1'b0;
         aud_on_q       <= 1'b0;
      end else begin
         if (codec_wr_done && codec_wr_addr == cps_pkg::CODEC_REG_AUD) begin
            aud_pend_q     <= 1'b1;
            aud_pend_val_q <= ena_bits;
         end else if (aud_pend_q && frm_rise) begin
            aud_pend_q <= 1'b0;
            aud_on_q   <= aud_pend_val_q;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tel_pend_q     <= 1'b0;
         tel_pend_val_q <= 1'b0;
         tel_on_q       <= 1'b0;
      end else begin
         if (codec_wr_done && codec_wr_addr == cps_pkg::CODEC_REG_TEL) begin
            tel_pend_q     <= 1'b1;
            tel_pend_val_q <= ena_bits;
         end else if (tel_pend_q && frm_rise) begin
            tel_pend_q <= 1'b0;
            tel_on_q   <= tel_pend_val_q;
         end
      end
   end

   // Level flags are live: a read returns occupancy of the read cycle
   always_comb begin
      status_word                   = sticky_q;
      status_word[cps_pkg::BIT_ANF] = ~aud_tx_full;
      status_word[cps_pkg::BIT_ANE] = ~aud_rx_empty;
      status_word[cps_pkg::BIT_TNF] = ~tel_tx_full;
      status_word[cps_pkg::BIT_TNE] = ~tel_rx_empty;
      status_word[cps_pkg::BIT_ACE] = aud_on_q;
      status_word[cps_pkg::BIT_TCE] = tel_on_q;
   end

   // Unmapped addresses and reserved bits read as zero
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_q <= '0;
      end else if (reg_rd) begin
         if (hit_status) begin
            rdata_q <= status_word;
         end else if (hit_mask) begin
            rdata_q <= mask_q;
         end else if (hit_ctrl) begin
            rdata_q <= {30'h0000_0000, ctrl_q};
         end else if (hit_rx) begin
            rdata_q <= {16'h0000, rx_word_q};
         end else begin
            rdata_q <= '0;
         end
      end else begin
         rdata_q <= '0;
      end
   end

   assign reg_rdata = rdata_q;

   // Transmit queue may be primed before the serial function is enabled
   assign fifo_full  = (cnt_q == 4'(cps_pkg::FIFO_DEPTH));
   assign fifo_empty = (cnt_q == '0);
   assign push       = reg_wr & hit_tx & ~fifo_full;
   assign pop        = ssf_active & (state_q == cps_pkg::CPS_IDLE) & frm_rise & ~fifo_empty;
   // Half-empty or lower asks for more data while the function is live
   assign tx_service_req = ssf_active & (cnt_q <= 4'(cps_pkg::FIFO_DEPTH / 2));

   always_ff @(posedge clk) begin
      if (push) begin
         fifo_mem[wr_ptr_q] <= reg_wdata[cps_pkg::WORD_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q    <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 3'h1;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 3'h1;
         end
         cnt_q <= cnt_q + {3'h0, push} - {3'h0, pop};
      end
   end

   // Shifter: frame start loads a word, rising clock drives, falling clock samples
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q   <= cps_pkg::CPS_IDLE;
         tx_sh_q   <= '0;
         rx_sh_q   <= '0;
         rx_word_q <= '0;
         bit_cnt_q <= '0;
         tx_pin_q  <= 1'b0;
      end else if (!ssf_active) begin
         state_q   <= cps_pkg::CPS_IDLE;
         bit_cnt_q <= '0;
         tx_pin_q  <= 1'b0;
      end else begin
         unique case (state_q)
            cps_pkg::CPS_IDLE: begin
               if (pop) begin
                  tx_sh_q   <= fifo_mem[rd_ptr_q];
                  bit_cnt_q <= '0;
                  state_q   <= cps_pkg::CPS_SHIFT;
               end
            end
            cps_pkg::CPS_SHIFT: begin
               if (sclk_rise) begin
                  tx_pin_q <= tx_sh_q[cps_pkg::WORD_W-1];
                  tx_sh_q  <= {tx_sh_q[cps_pkg::WORD_W-2:0], 1'b0};
               end
               if (sclk_fall) begin
                  rx_sh_q   <= {rx_sh_q[cps_pkg::WORD_W-2:0], rxp_s_q[1]};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
                  if (bit_cnt_q == cps_pkg::LAST_BIT) begin
                     rx_word_q <= {rx_sh_q[cps_pkg::WORD_W-2:0], rxp_s_q[1]};
                     state_q   <= cps_pkg::CPS_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // Pin holds the last bit after a frame and returns to zero when disabled
   assign serial_tx_pin = tx_pin_q;

endmodule

// ### bench/cps_status_sva.sv
// Checker for the codec port status word: reset state, flags and pin priority.
// Assumes it is bound to cps_status and sees only that module's ports.
`timescale 1ns/1ps
module cps_status_sva (
   input wire logic                       clk,
   input wire logic                       rst_n,
   input wire logic [cps_pkg::ADDR_W-1:0] reg_addr,
   input wire logic                       reg_rd,
   input wire logic [cps_pkg::DATA_W-1:0] reg_rdata,
   input wire logic                       irq,
   input wire logic                       tel_tx_fetch,
   input wire logic                       tel_tx_empty,
   input wire logic                       tel_rx_push,
   input wire logic                       tel_rx_full,
   input wire logic                       aud_tx_full,
   input wire logic                       aud_rx_empty,
   input wire logic                       tel_tx_full,
   input wire logic                       tel_rx_empty,
   input wire logic                       codec_wr_done,
   input wire logic                       codec_rd_done,
   input wire logic                       codec_port_en,
   input wire logic                       sync_serial_func_en,
   input wire logic                       pins_to_pin_controller,
   input wire logic                       tx_service_req
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence stat_rd;
      reg_rd && reg_addr == cps_pkg::OFF_STATUS;
   endsequence
   chk_reset_idle: assert property (!$past(rst_n) |-> pins_to_pin_controller && !codec_port_en && !irq)
      else $error("outputs not idle after reset");
   chk_port_priority: assert property (codec_port_en |-> !sync_serial_func_en)
      else $error("serial function on while codec port on");
   chk_underrun_seen: assert property ((tel_tx_fetch && tel_tx_empty) ##1 stat_rd |=> reg_rdata[6])
      else $error("underrun flag missing");
   chk_overrun_seen: assert property ((tel_rx_push && tel_rx_full) ##1 stat_rd |=> reg_rdata[7])
      else $error("overrun flag missing");
   chk_space_flags: assert property (stat_rd |=> reg_rdata[8] == !$past(aud_tx_full) && reg_rdata[10] == !$past(tel_tx_full))
      else $error("space flags wrong");
   chk_entry_flags: assert property (stat_rd |=> reg_rdata[9] == !$past(aud_rx_empty) && reg_rdata[11] == !$past(tel_rx_empty))
      else $error("entry flags wrong");
   chk_write_done: assert property (codec_wr_done ##1 stat_rd |=> reg_rdata[12])
      else $error("write done flag missing");
   chk_read_done: assert property (codec_rd_done ##1 stat_rd |=> reg_rdata[13])
      else $error("read done flag missing");
   chk_reserved_zero: assert property (stat_rd |=> reg_rdata[31:16] == 16'h0000)
      else $error("reserved bits not zero");
   cover property (irq);
   cover property (sync_serial_func_en && $rose(tx_service_req));
   cover property (reg_rd && reg_addr == cps_pkg::OFF_RXDATA);
endmodule
bind cps_status cps_status_sva u_sva (.clk, .rst_n, .reg_addr, .reg_rd, .reg_rdata, .irq, .tel_tx_fetch, .tel_tx_empty,
   .tel_rx_push, .tel_rx_full, .aud_tx_full, .aud_rx_empty, .tel_tx_full, .tel_rx_empty, .codec_wr_done, .codec_rd_done,
   .codec_port_en, .sync_serial_func_en, .pins_to_pin_controller, .tx_service_req);

// ### bench/cps_codec_model.sv
// Behavioural codec on the serial link: makes clock and frame, returns receive words.
// Assumes the bench calls send_frame; the link clock stays low between frames.
`timescale 1ns/1ps
module cps_codec_model (
   input  wire logic        serial_tx_pin,
   output logic             serial_clk_pin,
   output logic             serial_frame_pin,
   output logic             serial_rx_pin,
   output logic [15:0]      tx_word
);
   initial begin
      serial_clk_pin = 1'h0;
      serial_frame_pin = 1'h0;
      serial_rx_pin = 1'h1;
      tx_word = 16'h0000;
   end
   // Frame pulse first, then 16 clocks; no clock during the pulse to avoid a stray shift
   task automatic send_frame(input logic [15:0] rx_word);
      #7 serial_frame_pin = 1'h1;
      #160 serial_frame_pin = 1'h0;
      #160;
      for (int i = 15; i >= 0; i--) begin
         serial_clk_pin = 1'h1;
         serial_rx_pin = rx_word[i];
         #80 serial_clk_pin = 1'h0;
         tx_word = {tx_word[14:0], serial_tx_pin};
         #80;
      end
      // Released line shows the inverse of the last bit, never a held value
      serial_rx_pin = ~serial_rx_pin;
   endtask
endmodule

// ### bench/cps_status_tb_top.sv
// Self-checking bench for the codec port status word and its serial link.
// Assumes the codec model on the link and the checker bound to the design.
`timescale 1ns/1ps
module cps_status_tb_top;
   logic        clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, irq, tx_service_req, serial_tx_pin;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
   logic        tel_tx_fetch = 1'h0, tel_tx_empty = 1'h0, tel_rx_push = 1'h0, tel_rx_full = 1'h0;
   logic        aud_tx_full = 1'h0, aud_rx_empty = 1'h1, tel_tx_full = 1'h0, tel_rx_empty = 1'h1;
   logic        codec_wr_done = 1'h0, codec_rd_done = 1'h0;
   logic [3:0]  codec_wr_addr = 4'h0;
   logic [15:0] codec_wr_data = 16'h0, tx_word;
   logic        codec_port_en, sync_serial_func_en, pins_to_pin_controller;
   logic        serial_clk_pin, serial_frame_pin, serial_rx_pin;
   int          n_fail = 0, comparisons = 0;
   always #10 clk = ~clk;
   cps_status u_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .tel_tx_fetch,
      .tel_tx_empty, .tel_rx_push, .tel_rx_full, .aud_tx_full, .aud_rx_empty, .tel_tx_full, .tel_rx_empty,
      .codec_wr_done, .codec_wr_addr, .codec_wr_data, .codec_rd_done, .codec_port_en, .sync_serial_func_en,
      .pins_to_pin_controller, .serial_clk_pin, .serial_frame_pin, .serial_rx_pin, .serial_tx_pin, .tx_service_req);
   cps_codec_model u_codec (.serial_tx_pin, .serial_clk_pin, .serial_frame_pin, .serial_rx_pin, .tx_word);
   task automatic finish_test();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'h0;
      // One idle edge so a following strobe is never assigned twice in one step
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'h0;
      #1 d = reg_rdata;
      @(posedge clk);
   endtask
   // Event pulses, one bit each: rd done, wr done, rx push, tx fetch
   task automatic ev(input logic [3:0] m);
      {codec_rd_done, codec_wr_done, tel_rx_push, tel_tx_fetch} <= m;
      @(posedge clk);
      {codec_rd_done, codec_wr_done, tel_rx_push, tel_tx_fetch} <= 4'h0;
   endtask
   task automatic t_reset();
      #1 check({pins_to_pin_controller, codec_port_en, sync_serial_func_en, irq, serial_tx_pin, tx_service_req}, 32'h20);
      @(posedge clk);
      rd(cps_pkg::OFF_STATUS);
      check(d, 32'h0000_0500);
   endtask
   task automatic t_levels();
      for (int i = 0; i < 16; i++) begin
         {aud_tx_full, aud_rx_empty, tel_tx_full, tel_rx_empty} <= i[3:0];
         wr(cps_pkg::OFF_STATUS, 32'hFFFF_FF00);
         rd(cps_pkg::OFF_STATUS);
         check(d, {20'h0, ~i[0], ~i[1], ~i[2], ~i[3], 8'h00});
      end
      {aud_tx_full, aud_rx_empty, tel_tx_full, tel_rx_empty} <= 4'h5;
      wr(cps_pkg::OFF_MASK, 32'hFFFF_FFFF);
      rd(cps_pkg::OFF_MASK);
      check(d, 32'h0000_30C0);
   endtask
   task automatic t_events();
      ev(4'h1);
      rd(cps_pkg::OFF_STATUS);
      check(d, 32'h0000_0500);
      tel_tx_empty <= 1'h1;
      tel_rx_full <= 1'h1;
      ev(4'h1);
      rd(cps_pkg::OFF_STATUS);
      check(d, 32'h0000_0540);
      check(irq, 1'h1);
      ev(4'hE);
      rd(cps_pkg::OFF_STATUS);
      check(d, 32'h0000_35C0);
      wr(cps_pkg::OFF_STATUS, 32'h0000_0040);
      rd(cps_pkg::OFF_STATUS);
      check(d, 32'h0000_3580);
      wr(cps_pkg::OFF_STATUS, 32'h0000_3080);
      rd(cps_pkg::OFF_STATUS);
      check(d, 32'h0000_0500);
      check(irq, 1'h0);
      wr(cps_pkg::OFF_MASK, 32'h0);
      ev(4'h1);
      rd(cps_pkg::OFF_STATUS);
      check({d[30:0], irq}, 32'h0000_0A80);
      wr(cps_pkg::OFF_STATUS, 32'h0000_0040);
      tel_tx_empty <= 1'h0;
      tel_rx_full <= 1'h0;
   endtask
   // Enable flags follow the codec register only once the next frame starts
   task automatic codec_write(input logic [3:0] a, input logic [15:0] v);
      codec_wr_addr <= a;
      codec_wr_data <= v;
      ev(4'h4);
      u_codec.send_frame(16'h0000);
      repeat (6) @(posedge clk);
      rd(cps_pkg::OFF_STATUS);
   endtask
   task automatic t_codec_on();
      codec_write(cps_pkg::CODEC_REG_AUD, 16'h4000);
      check(d[15:14], 2'h1);
      codec_write(cps_pkg::CODEC_REG_TEL, 16'h8000);
      check(d[15:14], 2'h3);
      codec_write(cps_pkg::CODEC_REG_AUD, 16'h0000);
      check(d[15:14], 2'h2);
      wr(cps_pkg::OFF_STATUS, 32'h0000_1000);
   endtask
   task automatic t_serial();
      wr(cps_pkg::OFF_CTRL, 32'h3);
      #1 check({codec_port_en, sync_serial_func_en}, 2'h2);
      @(posedge clk);
      for (int i = 0; i < 9; i++)
         wr(cps_pkg::OFF_TXDATA, 32'hA000 + i);
      wr(cps_pkg::OFF_CTRL, 32'h0);
      wr(cps_pkg::OFF_CTRL, 32'h2);
      #1 check({pins_to_pin_controller, codec_port_en, sync_serial_func_en, tx_service_req}, 4'h2);
      for (int i = 0; i < 4; i++) begin
         u_codec.send_frame(16'h5A00 + i[15:0]);
         repeat (6) @(posedge clk);
         check(tx_word, 32'hA000 + i);
         rd(cps_pkg::OFF_RXDATA);
         check(d, 32'h5A00 + i);
      end
      #1 check(tx_service_req, 1'h1);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      t_reset();
      t_levels();
      t_events();
      t_codec_on();
      t_serial();
      finish_test();
   end
   initial begin
      #200000;
      n_fail++;
      finish_test();
   end
endmodule
